// ==== logic/wdog_defines.svh ====
// Offsets, field positions, reset values and counts of the watchdog.
// Assumes byte addresses on the plain register port, 32-bit data.
`ifndef WDOG_DEFINES_SVH
`define WDOG_DEFINES_SVH

// Register byte offsets
`define WDT_CTRL_ADDR   12'h100
`define WDT_SVC_ADDR    12'h104
`define WDT_STAT_ADDR   12'h108

// Control field positions
`define WDT_F_WIN       0
`define WDT_F_LONG      1
`define WDT_F_TSEL_LO   2
`define WDT_F_CSEL_LO   4
`define WDT_F_STOP_RUN  6
`define WDT_F_DBG_RUN   7
`define WDT_CTRL_W      8

// Control reset value: 1 kHz source, select 11, short timeout
`define WDT_CTRL_RESET  8'h0c

// Service sequence keys
`define WDT_KEY_FIRST   32'h0000_0055
`define WDT_KEY_SECOND  32'h0000_00aa

// Overflow counts in counting cycles
`define WDT_OVF_S1      32
`define WDT_OVF_S2      256
`define WDT_OVF_S3      1024
`define WDT_OVF_L1      8192
`define WDT_OVF_L2      65536
`define WDT_OVF_L3      262144

`endif

// ==== logic/wdog_pkg.sv ====
// Types shared by the watchdog design and its bench.
// Assumes wdog_defines.svh sits beside it.
`include "wdog_defines.svh"

package wdog_pkg;

  // Counting clock sources
  typedef enum logic [1:0] {
    SRC_LPO  = 2'h0,
    SRC_IRC  = 2'h1,
    SRC_XTAL = 2'h2,
    SRC_BUS  = 2'h3
  } clk_src_e;

  // Control register layout, msb first
  typedef struct packed {
    logic       debug_run_enable;
    logic       stop_run_enable;
    clk_src_e   count_clock_select;
    logic [1:0] timeout_select;
    logic       long_timeout_bit;
    logic       window_enable;
  } ctrl_s;

  // Service sequence progress, one-hot
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b01,
    SEQ_ARMED = 2'b10
  } seq_e;

  // Register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

endpackage

// ==== logic/windowed_watchdog_timer.sv ====
// Windowed watchdog: service register, write-once control, counter.
// Assumes the bus clock is sys_clk_in; other counting clocks are pins.
//
// What this block does
// - Comes up enabled and counting after reset.
// - Timeout select 00 disables the watchdog.
// - 0x55 then 0xAA clears the counter.
// - Service writes store nothing.
// - Overflow before service asserts system reset.
// - Other service value resets immediately.
// - Defaults: 1 kHz source, 2^10 overflow.
// - Clock select chooses the counting clock.
// - Overflow count from select and long bit.
// - Windowed: service only in last quarter.
// - Early windowed service resets immediately.
// - Short timeout ignores window enable.
// - Control register is write-once per reset.
// - Non-1 kHz sources halt in debug/stop.
// - Counter clears on debug/stop entry.
// - Run enables keep counting in debug/stop.
// - Bus clock with stop-run holds in stop.
// - Deepest low-leakage stop disables the watchdog.
//
// Register map on the plain port
//   Control, offset 0x100, read and write, write-once per reset
//     bit 0     window enable, honoured only with the long timeout
//     bit 1     long timeout bit
//     bits 3:2  timeout select, 00 turns the watchdog off
//     bits 5:4  counting clock select, 11 picks the bus clock
//     bit 6     stop-run enable
//     bit 7     debug-run enable
//   Service, offset 0x104, write only, reads as zero
//     0x55 arms the sequence, 0xaa right after it restarts the period
//     Any other word requests a system reset at once
//   Status, offset 0x108, read only
//     bits 17:0 counter
//     bit 18    service sequence armed
//     bit 19    watchdog enabled
//     bit 20    control locked
//
// Timing on the register port
//   Writes take effect at the edge that samples the write strobe
//   Read data stand only in the cycle after the read strobe
//   The port never stalls; strobes may follow back to back
//
// Counting
//   Pin clocks pass two flops; a third flop finds the rising edge
//   Each rising edge of the selected pin is one counting cycle
//   The bus clock source counts once per bus cycle
//   Pin clocks must run below half the bus clock or edges are lost
//   The ovf-th counting cycle raises the reset request
//   The counter then holds at its last value until reset or a counter clear
//
// Window
//   With window and long timeout set, service opens at 3/4 of ovf
//   Either key written before that point resets at once
//
// Modes
//   Debug or stop entry clears the counter unless its run bit is set
//   Sources other than 1 kHz freeze in debug or stop unless allowed
//   The bus source always freezes in stop
//   Deepest low-leakage stop holds the counter at zero, ignores service
//   Mode inputs come from logic on the bus clock and pass no flops
//
// Reset request
//   Registered and sticky; only the system reset clears it
//   The surrounding system is expected to turn it into nrst_in
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`include "wdog_defines.svh"

module windowed_watchdog_timer
  import wdog_pkg::*;
#(
  parameter int CNT_W   = 18,
  parameter int OVF_L1  = `WDT_OVF_L1,
  parameter int OVF_L2  = `WDT_OVF_L2,
  parameter int OVF_L3  = `WDT_OVF_L3
)(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        nrst_in,
  // Register port
  input  wire logic [11:0] reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // Counting clock pins
  input  wire logic        lpo_clk_in,
  input  wire logic        irc_clk_in,
  input  wire logic        xtal_clk_in,
  // Power and debug modes
  input  wire logic        debug_mode_in,
  input  wire logic        stop_mode_in,
  input  wire logic        deep_stop_in,
  // System reset request
  output logic             sys_reset_req_out
);

  localparam int CW1 = CNT_W + 1;

  // Long counts must fit the counter and split into quarters
  generate
    if (OVF_L3 > (1 << CNT_W) || OVF_L1 % 4 != 0 || OVF_L2 % 4 != 0 ||
        OVF_L3 % 4 != 0 || OVF_L1 < 4 || `WDT_OVF_S3 > (1 << CNT_W))
    begin : g_bad_counts
      $error("windowed_watchdog_timer: counts do not fit the counter");
    end
  endgenerate

  // Register hit for a request, shared by the write strobes
  function automatic logic hits(input reg_req_s r, input logic [11:0] a);
    hits = (r.addr == a);
  endfunction

  // Overflow length for a control setting, zero when disabled
  function automatic logic [CNT_W:0] ovf_len(input ctrl_s c);
    logic [2:0] key;
    key = {c.long_timeout_bit, c.timeout_select};
    case (key)
      3'h1:    ovf_len = CW1'(`WDT_OVF_S1);
      3'h2:    ovf_len = CW1'(`WDT_OVF_S2);
      3'h3:    ovf_len = CW1'(`WDT_OVF_S3);
      3'h5:    ovf_len = CW1'(OVF_L1);
      3'h6:    ovf_len = CW1'(OVF_L2);
      3'h7:    ovf_len = CW1'(OVF_L3);
      default: ovf_len = '0;
    endcase
  endfunction

  // Bus request bundle
  reg_req_s          req;
  // Stored control and lock
  ctrl_s             ctrl_ff;
  logic              locked_ff;
  // Counter and service progress
  logic [CNT_W-1:0]  count_ff;
  logic [CNT_W-1:0]  nxt_count;
  seq_e              seq_ff;
  // Mode history for entry detection
  logic              debug_q_ff;
  logic              stop_q_ff;
  // Pin clock synchronisers and edge stage
  logic [2:0]        sync1_ff;
  logic [2:0]        sync2_ff;
  logic [2:0]        sync3_ff;
  logic [2:0]        pin_tick;
  // Derived controls
  logic [CNT_W:0]    ovf;
  logic [CNT_W:0]    win_open;
  logic              enabled;
  logic              windowed;
  logic              tick;
  logic              halt;
  logic              entry_clear;
  logic              ctrl_wr;
  logic              svc_wr;
  logic              svc_done;
  logic              svc_bad;
  logic              overflow_hit;
  logic              early;

  assign req = '{addr: reg_addr_in, wdata: reg_wdata_in,
                 wr: reg_wr_in, rd: reg_rd_in};

  // Pins pass two flops; third flop only for the edge
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_pin
      always_ff @(posedge sys_clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
          sync3_ff[gi] <= 1'b0;
        end
        else
        begin
          sync1_ff[gi] <= (gi == 0) ? lpo_clk_in :
                          (gi == 1) ? irc_clk_in : xtal_clk_in;
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
        end
      end
      // Rising edge of the synchronised pin clock
      assign pin_tick[gi] = sync2_ff[gi] & ~sync3_ff[gi];
    end
  endgenerate

  // Counting tick from the selected source
  always_comb
  begin
    unique case (ctrl_ff.count_clock_select)
      SRC_LPO:  tick = pin_tick[0];
      SRC_IRC:  tick = pin_tick[1];
      SRC_XTAL: tick = pin_tick[2];
      SRC_BUS:  tick = 1'b1;
    endcase
  end

  // Limits and mode decode
  assign ovf      = ovf_len(ctrl_ff);
  assign win_open = ovf - (ovf >> 2);
  // Deepest stop turns counting and service off
  assign enabled  = (ctrl_ff.timeout_select != 2'h0)
                    && !deep_stop_in;
  // Window only with the long timeout
  assign windowed = ctrl_ff.window_enable
                    && ctrl_ff.long_timeout_bit;

  // Halt non-1 kHz increment in debug or stop unless allowed to run; bus always halts in stop
  always_comb
  begin
    halt = 1'b0;
    if (ctrl_ff.count_clock_select != SRC_LPO)
    begin
      // Non-1 kHz sources freeze in debug and stop
      halt = (debug_mode_in && !ctrl_ff.debug_run_enable) ||
             (stop_mode_in && !ctrl_ff.stop_run_enable);
    end
    if (ctrl_ff.count_clock_select == SRC_BUS && stop_mode_in)
      halt = 1'b1;
  end

  // Entry into debug or stop clears unless run is enabled
  assign entry_clear =
    (debug_mode_in && !debug_q_ff && !ctrl_ff.debug_run_enable) ||
    (stop_mode_in && !stop_q_ff && !ctrl_ff.stop_run_enable);

  // Register strobes
  assign ctrl_wr = req.wr && hits(req, `WDT_CTRL_ADDR);
  assign svc_wr  = req.wr && hits(req, `WDT_SVC_ADDR) && enabled;
  assign early   = windowed && CW1'(count_ff) < win_open;

  // Completed pair restarts the period
  assign svc_done = svc_wr && req.wdata == `WDT_KEY_SECOND
                    && seq_ff == SEQ_ARMED && !early;
  // Wrong value or early windowed write resets now
  assign svc_bad  = svc_wr && ((req.wdata != `WDT_KEY_FIRST &&
                                req.wdata != `WDT_KEY_SECOND)
                               || early);
  // Last cycle of the period reached
  assign overflow_hit = enabled && tick && !halt
                        && CW1'(count_ff) == ovf - CW1'(1);

  // Mode history
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      debug_q_ff <= 1'b0;
      stop_q_ff  <= 1'b0;
    end
    else
    begin
      debug_q_ff <= debug_mode_in;
      stop_q_ff  <= stop_mode_in;
    end
  end

  // Write-once control register
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ctrl_ff   <= ctrl_s'(`WDT_CTRL_RESET);
      locked_ff <= 1'b0;
    end
    else if (ctrl_wr && !locked_ff)
    begin
      // First write fixes the settings
      ctrl_ff   <= ctrl_s'(req.wdata[`WDT_CTRL_W-1:0]);
      locked_ff <= 1'b1;
    end
  end

  // Next counter value
  always_comb
  begin
    nxt_count = count_ff;
    if (!enabled)
      nxt_count = '0;
    else if (ctrl_wr && !locked_ff)
      nxt_count = '0;
    else if (svc_done || entry_clear)
      nxt_count = '0;
    else if (overflow_hit)
      nxt_count = count_ff;  // Hold at the last count, request is out
    else if (tick && !halt)
      nxt_count = count_ff + CNT_W'(1);
  end

  // Counter
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      count_ff <= '0;
    else
      count_ff <= nxt_count;
  end

  // Service sequence tracker; the register itself holds nothing
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      seq_ff <= SEQ_IDLE;
    else if (!enabled)
      seq_ff <= SEQ_IDLE;
    else if (svc_wr)
    begin
      // Arm on first key, anything else disarms
      if (req.wdata == `WDT_KEY_FIRST)
        seq_ff <= SEQ_ARMED;
      else
        seq_ff <= SEQ_IDLE;
    end
  end

  // Sticky reset request until the system reset arrives
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      sys_reset_req_out <= 1'b0;
    else if (svc_bad || overflow_hit)
      sys_reset_req_out <= 1'b1;
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      reg_rdata_out <= '0;
    else if (req.rd)
    begin
      unique case (req.addr)
        // Control value, upper bits zero
        `WDT_CTRL_ADDR: reg_rdata_out <= 32'(ctrl_ff);
        // Service register keeps nothing
        `WDT_SVC_ADDR:  reg_rdata_out <= '0;
        // Lock, enable, armed, counter
        `WDT_STAT_ADDR: reg_rdata_out <= 32'({locked_ff, enabled,
                                              seq_ff == SEQ_ARMED, count_ff});
        default:        reg_rdata_out <= '0;
      endcase
    end
    else
      reg_rdata_out <= '0;
  end

endmodule // windowed_watchdog_timer

// ==== bench/wdog_props.sv ====
// Port checker for the watchdog, bound to the top module below.
// Assumes one clock domain and the control map of wdog_defines.svh.
`timescale 1ns/1ns
`include "wdog_defines.svh"
module wdog_props
  import wdog_pkg::*;
#(
  parameter int OVF_L1 = 16,
  parameter int OVF_L2 = 32,
  parameter int OVF_L3 = 64
)(
  // Clock, reset and register port
  input wire logic        sys_clk_in,
  input wire logic        nrst_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // Mode and reset request
  input wire logic        deep_stop_in,
  input wire logic        sys_reset_req_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  logic [7:0] ctrl_ff; // Shadow of control
  logic       lock_ff; // Control taken
  logic       en_w;    // Select nonzero
  int         ovf_w;   // Overflow count
  // Shadow takes only the first control write
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ctrl_ff <= `WDT_CTRL_RESET;
      lock_ff <= 1'b0;
    end
    else if (reg_wr_in && reg_addr_in == `WDT_CTRL_ADDR && !lock_ff)
    begin
      ctrl_ff <= reg_wdata_in[7:0];
      lock_ff <= 1'b1;
    end
  end
  // Overflow from select and long bit
  always_comb
  begin
    en_w = ctrl_ff[`WDT_F_TSEL_LO +: 2] != 2'h0;
    case ({ctrl_ff[`WDT_F_LONG], ctrl_ff[`WDT_F_TSEL_LO +: 2]})
      3'h1: ovf_w = `WDT_OVF_S1;
      3'h2: ovf_w = `WDT_OVF_S2;
      3'h3: ovf_w = `WDT_OVF_S3;
      3'h5: ovf_w = OVF_L1;
      3'h6: ovf_w = OVF_L2;
      default: ovf_w = OVF_L3;
    endcase
  end
  sequence s_stat_rd;
    reg_rd_in && reg_addr_in == `WDT_STAT_ADDR;
  endsequence
  sequence s_svc_wr;
    reg_wr_in && reg_addr_in == `WDT_SVC_ADDR;
  endsequence
  a_ctrl_read_back: assert property (
    reg_rd_in && reg_addr_in == `WDT_CTRL_ADDR |=> reg_rdata_out == {24'h0, $past(ctrl_ff)})
    else $error("control read back wrong");
  a_svc_reads_zero: assert property (
    reg_rd_in && reg_addr_in == `WDT_SVC_ADDR |=> reg_rdata_out == 32'h0)
    else $error("service register read not zero");
  a_req_sticky: assert property (
    sys_reset_req_out |=> sys_reset_req_out) else $error("reset request dropped");
  a_bad_key_reset: assert property (
    s_svc_wr ##0 (reg_wdata_in != `WDT_KEY_FIRST && reg_wdata_in != `WDT_KEY_SECOND
      && en_w && !deep_stop_in) |=> sys_reset_req_out) else $error("bad key no reset");
  a_off_quiet: assert property (
    !en_w && !sys_reset_req_out |=> !sys_reset_req_out) else $error("reset while off");
  a_deep_quiet: assert property (
    deep_stop_in && !sys_reset_req_out |=> !sys_reset_req_out)
    else $error("reset in deep stop");
  a_cnt_below_ovf: assert property (
    s_stat_rd |=> reg_rdata_out[17:0] < $past(ovf_w)) else $error("counter past overflow");
  a_status_flags: assert property (
    s_stat_rd |=> reg_rdata_out[20:19] == $past({lock_ff, en_w && !deep_stop_in}))
    else $error("status flags wrong");
endmodule // wdog_props

bind windowed_watchdog_timer wdog_props #(
  .OVF_L1(OVF_L1), .OVF_L2(OVF_L2), .OVF_L3(OVF_L3)
) u_props (
  .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .deep_stop_in(deep_stop_in),
  .sys_reset_req_out(sys_reset_req_out)
);

// ==== bench/tb_windowed_watchdog_timer.sv ====
// Self-checking bench for the watchdog over its register port.
// Assumes small long-timeout counts; pins toggle every 4 bus cycles.
`timescale 1ns/1ns
`include "wdog_defines.svh"
module tb_windowed_watchdog_timer
  import wdog_pkg::*;
;
  localparam int L1 = 16;
  localparam int L2 = 32;
  localparam int L3 = 64;
  logic        clk;       // Bus clock
  logic        rst_n;     // Reset, active low
  logic [11:0] addr;      // Register address
  logic [31:0] wdata;     // Write data
  logic        wr_stb;    // Write strobe
  logic        rd_stb;    // Read strobe
  logic [31:0] rdata;     // Read data
  logic        dbg;       // Debug mode
  logic        stp;       // Stop mode
  logic        deep;      // Deep stop
  logic        req;       // Reset request
  logic [2:0]  pin_en;    // Active counting pins
  logic [2:0]  div;       // Slow pin divider
  logic [31:0] d0;        // Read results
  logic [31:0] d1;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int ovf [6] = '{`WDT_OVF_S1, `WDT_OVF_S2, `WDT_OVF_S3, L1, L2, L3};
  windowed_watchdog_timer #(.OVF_L1(L1), .OVF_L2(L2), .OVF_L3(L3)) uut (
    .sys_clk_in(clk), .nrst_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr_stb), .reg_rd_in(rd_stb), .reg_rdata_out(rdata),
    .lpo_clk_in(pin_en[0] & div[2]), .irc_clk_in(pin_en[1] & div[2]),
    .xtal_clk_in(pin_en[2] & div[2]), .debug_mode_in(dbg), .stop_mode_in(stp),
    .deep_stop_in(deep), .sys_reset_req_out(req));
  // Bus clock, 100 ns
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Pin divider and hang guard
  always @(posedge clk)
  begin
    div <= div + 3'h1;
    cyc++;
    if (cyc == 10000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("mismatches %0d of %0d checks", bad_count, n_checks);
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bw(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic br(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  // Reset for 16 cycles, then lock control unless c is zero
  task automatic cfg(input logic [7:0] c);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    if (c != 8'h0) bw(`WDT_CTRL_ADDR, {24'h0, c});
  endtask
  // Service from the main sequence, never from a handler
  task automatic svc();
    bw(`WDT_SVC_ADDR, `WDT_KEY_FIRST);
    bw(`WDT_SVC_ADDR, `WDT_KEY_SECOND);
  endtask
  // Main sequence
  initial
  begin
    rst_n = 1'b0; addr = 12'h0; wdata = 32'h0; wr_stb = 1'b0; rd_stb = 1'b0;
    dbg = 1'b0; stp = 1'b0; deep = 1'b0; pin_en = 3'h7; div = 3'h0;
    cfg(8'h0);
    br(`WDT_CTRL_ADDR, d0);
    chk_word(d0, 32'h0000_000c);
    idle(40);
    br(`WDT_STAT_ADDR, d0);
    chk_bit(d0[19] && !d0[20] && d0[17:0] != 0, 1'b1);
    bw(`WDT_SVC_ADDR, `WDT_KEY_FIRST);
    br(`WDT_SVC_ADDR, d0);
    chk_word(d0, 32'h0);
    bw(`WDT_CTRL_ADDR, 32'h34);
    bw(`WDT_CTRL_ADDR, 32'h0);
    br(`WDT_CTRL_ADDR, d0);
    chk_word(d0, 32'h34);
    idle(10);
    svc();
    br(`WDT_STAT_ADDR, d0);
    chk_bit(d0[17:0] < 8, 1'b1);
    idle(8);
    bw(`WDT_SVC_ADDR, `WDT_KEY_SECOND);
    br(`WDT_STAT_ADDR, d0);
    chk_bit(d0[17:0] >= 8, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      cfg(8'h30 | 8'(i / 3 * 2) | 8'((i % 3 + 1) << 2));
      idle(ovf[i] - 6);
      chk_bit(req, 1'b0);
      idle(10);
      chk_bit(req, 1'b1);
    end
    for (int s = 0; s < 3; s++)
    begin
      pin_en <= 3'(1 << s);
      cfg(8'(s << 4) | 8'h0c);
      idle(80);
      br(`WDT_STAT_ADDR, d0);
      chk_bit(d0[17:0] >= 8 && d0[17:0] <= 12, 1'b1);
    end
    cfg(8'h3f);
    idle(20);
    bw(`WDT_SVC_ADDR, `WDT_KEY_FIRST);
    idle(1);
    chk_bit(req, 1'b1);
    cfg(8'h3f);
    idle(50);
    svc();
    idle(40);
    chk_bit(req, 1'b0);
    cfg(8'h35);
    svc();
    idle(28);
    chk_bit(req, 1'b0);
    cfg(8'h30);
    idle(40);
    bw(`WDT_SVC_ADDR, 32'h12);
    idle(2);
    chk_bit(req, 1'b0);
    cfg(8'h3c);
    idle(20);
    stp <= 1'b1;
    idle(5);
    br(`WDT_STAT_ADDR, d0);
    chk_bit(d0[17:0] == 0, 1'b1);
    stp <= 1'b0;
    idle(10);
    dbg <= 1'b1;
    idle(5);
    br(`WDT_STAT_ADDR, d0);
    chk_bit(d0[17:0] == 0, 1'b1);
    dbg <= 1'b0;
    cfg(8'hfc);
    idle(20);
    stp <= 1'b1;
    br(`WDT_STAT_ADDR, d0);
    idle(10);
    br(`WDT_STAT_ADDR, d1);
    chk_bit(d1[17:0] == d0[17:0] && d0[17:0] >= 20, 1'b1);
    stp <= 1'b0;
    dbg <= 1'b1;
    br(`WDT_STAT_ADDR, d0);
    idle(10);
    br(`WDT_STAT_ADDR, d1);
    chk_bit(d1[17:0] > d0[17:0] + 10, 1'b1);
    dbg <= 1'b0;
    deep <= 1'b1;
    idle(3);
    bw(`WDT_SVC_ADDR, 32'h12);
    idle(2);
    chk_bit(req, 1'b0);
    deep <= 1'b0;
    bw(`WDT_SVC_ADDR, 32'h155);
    idle(1);
    chk_bit(req, 1'b1);
    give_verdict();
  end
endmodule // tb_windowed_watchdog_timer
